//--- dv/gpib_ctrl_model.sv
// controller-side model issuing bus messages and poll configuration bytes
`timescale 1ns/1ps
module gpib_ctrl_model (
	input  wire logic i_clk_sys,
	output logic [8:0] o_msg,
	output logic       o_sec_valid,
	output logic [7:0] o_sec_byte
);
	initial begin
		o_msg = 9'h000;
		o_sec_valid = 1'b0;
		o_sec_byte = 8'h00;
	end
	// single-cycle message: 0 trigger, 1 clear, 2 selected clear, 3 local,
	// 4 lockout, 5 configure, 6 unconfigure, 7 serial poll on, 8 serial poll off
	task automatic pulse(input int k);
		@(posedge i_clk_sys) #1 o_msg = 9'h001 << k;
		@(posedge i_clk_sys) #1 o_msg = 9'h000;
	endtask
	// configure then the secondary byte; released byte lines show the inverse
	task automatic sec(input logic [7:0] b);
		pulse(5);
		o_sec_valid = 1'b1;
		o_sec_byte = b;
		@(posedge i_clk_sys) #1 o_sec_valid = 1'b0;
		o_sec_byte = ~b;
	endtask
	// enable byte: 0110, sense level, line number
	task automatic ppe(input logic s, input logic [2:0] d);
		sec({4'h6, s, d});
	endtask
	// disable byte with only bits 4 to 6 set
	task automatic ppd();
		sec(8'h70);
	endtask
endmodule

//--- dv/gpib_status_poll_trigger_unit_bench.sv
// self-checking bench for the status, poll and trigger unit
`timescale 1ns/1ps
module gpib_status_poll_trigger_unit_bench import status_poll_pkg::*;;
	localparam int TLEN = 20;
	logic         clk = 1'b0, rstn = 1'b0, cvalid = 1'b0, ops = 1'b0, wt = 1'b0;
	logic         fail = 1'b0, key = 1'b0, ren = 1'b0, listen = 1'b0, ppoll = 1'b0;
	cmd_type      cmd = CMD_NONE;
	trig_src_type src = SRC_BUS;
	logic [7:0]   cdata = 8'h00, mask = 8'h00, rd, dio, sbyte, sec_b;
	logic [5:0]   st = 6'h00;
	logic [8:0]   msg;
	logic         sec_v, ready, rv, ev, trig, frun, clr, rem, lock, srq, smode;
	logic [15:0]  ecode;
	int           err_total = 0, total_checks = 0;
	logic [31:0]  seed = 32'h00010612; // xorshift state, starts at 67090
	initial begin
		forever #5 clk = ~clk;
	end
	gpib_status_poll_trigger_unit #(.SELFTEST_LEN(SELFTEST_W'(TLEN)))
	gpib_status_poll_trigger_unit_i (
		.i_clk_sys(clk), .i_rstn(rstn), .i_cmd_valid(cvalid), .i_cmd(cmd), .i_cmd_data(cdata),
		.o_cmd_ready(ready), .i_bus_get(msg[0]), .i_bus_dcl(msg[1]), .i_bus_sdc(msg[2]),
		.i_bus_gtl(msg[3]), .i_bus_llo(msg[4]), .i_bus_ren(ren), .i_bus_ppc(msg[5]),
		.i_bus_ppu(msg[6]), .i_bus_sec_valid(sec_v), .i_bus_sec_byte(sec_b), .i_bus_spe(msg[7]),
		.i_bus_spd(msg[8]), .i_listen_addr(listen), .i_ppoll(ppoll), .i_dev_dep(st[0]),
		.i_err_queue_nonempty(st[1]), .i_quest_sum(st[2]), .i_out_msg_ready(st[3]),
		.i_event_sum(st[4]), .i_oper_sum(st[5]), .i_ops_pending(ops), .i_trig_src(src),
		.i_chan_waiting(wt), .i_selftest_fail(fail), .i_local_key(key), .o_resp_valid(rv),
		.o_resp_data(rd), .o_err_valid(ev), .o_err_code(ecode), .o_trigger(trig),
		.o_set_free_run(frun), .o_clear(clr), .o_remote(rem), .o_lockout(lock), .o_srq(srq),
		.o_ppoll_dio(dio), .o_spoll_mode(smode), .o_spoll_byte(sbyte));
	gpib_ctrl_model gpib_ctrl_model_i (.i_clk_sys(clk), .o_msg(msg), .o_sec_valid(sec_v),
		.o_sec_byte(sec_b));
	// repeatable pseudo-random words
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// status byte expected from the sources and the mask
	function automatic logic [7:0] stb_exp(input logic [5:0] s, input logic [7:0] m);
		logic [7:0] b;
		b = {s[5], 1'b0, s[4:0], 1'b0};
		b[6] = |(b & m & 8'hbf);
		return b;
	endfunction
	// counted comparison, reported at once on a mismatch
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// hold a command until the edge that takes it, then release
	task automatic send(input cmd_type c, input logic [7:0] d);
		int n = 0;
		@(posedge clk) #1 cvalid = 1'b1;
		cmd = c;
		cdata = d;
		// ready is read settled, before the edge that takes the command
		while (ready !== 1'b1 && n < 200) begin
			@(posedge clk) #1;
			n++;
		end
		if (n >= 200) check(ready, 1);
		@(posedge clk) #1 cvalid = 1'b0;
	endtask
	task automatic print_verdict();
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// cut a hang short far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		// mask write and read back, corners then random
		for (int i = 0; i < 8; i++) begin
			mask = (i == 0) ? 8'hff : (i == 1) ? 8'h40 : 8'(rnd());
			send(CMD_SRE_SET, mask);
			send(CMD_SRE_QRY, 8'h00);
			check({rv, rd}, {1'b1, mask & 8'hbf});
		end
		// random sources against the computed status byte
		for (int i = 0; i < 12; i++) begin
			logic [7:0] e;
			mask = 8'(rnd());
			send(CMD_SRE_SET, mask);
			st = 6'(rnd());
			e = stb_exp(st, mask);
			tick(2);
			check({srq, sbyte}, {e[6], e});
			send(CMD_STB_QRY, 8'h00);
			check(rd, e);
		end
		// every source, channel waiting or not, by command and by bus message
		for (int k = 0; k < 16; k++) begin
			src = trig_src_type'(k[1:0]);
			wt = k[2];
			listen = 1'(rnd()); // addressing must not matter to triggers
			if (k[3]) gpib_ctrl_model_i.pulse(0);
			else send(CMD_TRG, 8'h00);
			check({trig, ev}, (src == SRC_BUS && wt) ? 16'h2 : 16'h1);
			if (ev === 1'b1) check(ecode, ERR_TRIG_IGNORED);
		end
		// wait released by completion, device clear, addressed selected clear
		for (int k = 0; k < 3; k++) begin
			ops = 1'b1;
			send(CMD_WAI, 8'h00);
			tick(4);
			check(ready, 0);
			if (k == 0) ops = 1'b0;
			else begin
				listen = 1'b0;
				gpib_ctrl_model_i.pulse(2);
				check({clr, ready}, 0);
				listen = (k == 2);
				gpib_ctrl_model_i.pulse(k);
				check(clr, 1);
			end
			tick(2);
			check(ready, 1);
			ops = 1'b0;
		end
		// self test passing then failing, answer after the set length
		for (int k = 0; k < 2; k++) begin
			int n;
			fail = k[0];
			send(CMD_TST_QRY, 8'h00);
			for (n = 1; rv !== 1'b1 && n < 100; n++) tick(1);
			// answer is registered one cycle after the timer's done pulse
			check(n, TLEN + 2);
			check(rd, k ? TST_FAIL_CHAR : TST_PASS_CHAR);
		end
		// remote, lockout holds against the key, then back to local
		ren = 1'b1;
		listen = 1'b1;
		gpib_ctrl_model_i.pulse(4);
		tick(1);
		check(lock, 1);
		key = 1'b1;
		tick(6);
		key = 1'b0;
		check(rem, 1);
		listen = 1'b0;
		gpib_ctrl_model_i.pulse(3);
		check(frun, 1);
		tick(1);
		check(rem, 0);
		gpib_ctrl_model_i.pulse(7);
		check(smode, 1);
		gpib_ctrl_model_i.pulse(8);
		check(smode, 0);
		// parallel poll by sense level, then selective and universal disable
		listen = 1'b1;
		send(CMD_SRE_SET, 8'h10);
		for (int k = 0; k < 6; k++) begin
			logic [4:0] r;
			logic       hit;
			r = 5'(rnd());
			st = {2'b00, r[4], 3'b000};
			gpib_ctrl_model_i.ppe(r[3], r[2:0]);
			if (k == 4) gpib_ctrl_model_i.ppd();
			if (k == 5) gpib_ctrl_model_i.pulse(6);
			ppoll = 1'(rnd());
			hit = ppoll && k < 4 && r[4] == r[3];
			tick(2);
			check(dio, hit ? 8'h01 << r[2:0] : 8'h00);
			ppoll = 1'b0;
			tick(1);
		end
		print_verdict();
	end
endmodule

//--- dv/gpib_unit_props.sv
// concurrent checks on the status, poll and trigger unit ports
`timescale 1ns/1ps
module gpib_unit_props
	import status_poll_pkg::*;
#(
	parameter logic [SELFTEST_W-1:0] SELFTEST_LEN = SELFTEST_W'(SELFTEST_CYCLES)
) (
	input wire logic         i_clk_sys,
	input wire logic         i_rstn,
	input wire logic         i_cmd_valid,
	input wire cmd_type      i_cmd,
	input wire logic         o_cmd_ready,
	input wire logic         i_bus_get,
	input wire logic         i_bus_dcl,
	input wire logic         i_bus_gtl,
	input wire logic         i_bus_llo,
	input wire logic         i_bus_ren,
	input wire logic         i_ppoll,
	input wire logic         i_ops_pending,
	input wire trig_src_type i_trig_src,
	input wire logic         i_chan_waiting,
	input wire logic         o_resp_valid,
	input wire logic [7:0]   o_resp_data,
	input wire logic         o_err_valid,
	input wire logic [15:0]  o_err_code,
	input wire logic         o_trigger,
	input wire logic         o_set_free_run,
	input wire logic         o_clear,
	input wire logic         o_lockout,
	input wire logic         o_srq,
	input wire logic [7:0]   o_ppoll_dio,
	input wire logic [7:0]   o_spoll_byte
);
	// a command is taken where strobe and ready meet; a trigger comes either way
	wire tk  = i_cmd_valid && o_cmd_ready;
	wire trg = (tk && i_cmd == CMD_TRG) || i_bus_get;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// answers, status byte and trigger outcome
	AST_MASK_QRY: assert property (tk && i_cmd == CMD_SRE_QRY
		|=> o_resp_valid && !o_resp_data[6]) else $error("mask query answer");
	AST_SUMMARY: assert property (o_srq == o_spoll_byte[6] && !o_spoll_byte[0])
		else $error("summary flag");
	AST_TRIG_OK: assert property (trg && i_trig_src == SRC_BUS && i_chan_waiting
		|=> o_trigger && !o_err_valid) else $error("trigger lost");
	AST_TRIG_BAD: assert property (trg && (i_trig_src != SRC_BUS || !i_chan_waiting)
		|=> o_err_valid && o_err_code == 16'hff2d && !o_trigger) else $error("trigger taken");
	// hold-off, clear and local control
	AST_WAI_HOLD: assert property (tk && i_cmd == CMD_WAI && i_ops_pending && !i_bus_dcl
		|=> !o_cmd_ready [*2]) else $error("wait not held");
	AST_CLEAR: assert property (i_bus_dcl |=> o_clear ##[1:3] o_cmd_ready)
		else $error("clear missing");
	AST_GTL: assert property (i_bus_gtl && i_bus_ren |=> o_set_free_run)
		else $error("free run missing");
	// lockout state settles one cycle after the message, its output one more
	AST_LLO: assert property (i_bus_llo && i_bus_ren ##1 i_bus_ren |=> o_lockout)
		else $error("lockout missing");
	AST_PPOLL: assert property (!i_ppoll |=> o_ppoll_dio == 8'h00 && $onehot0(o_ppoll_dio))
		else $error("poll lines driven");
	C_TRIG: cover property (trg && i_trig_src == SRC_BUS && i_chan_waiting);
	C_WAI: cover property (tk && i_cmd == CMD_WAI && i_ops_pending);
	C_POLL: cover property (i_ppoll && o_srq);
endmodule
bind gpib_status_poll_trigger_unit gpib_unit_props #(.SELFTEST_LEN(SELFTEST_LEN)) gpib_unit_props_i (
	.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
	.o_cmd_ready(o_cmd_ready), .i_bus_get(i_bus_get), .i_bus_dcl(i_bus_dcl),
	.i_bus_gtl(i_bus_gtl), .i_bus_llo(i_bus_llo), .i_bus_ren(i_bus_ren), .i_ppoll(i_ppoll),
	.i_ops_pending(i_ops_pending), .i_trig_src(i_trig_src), .i_chan_waiting(i_chan_waiting),
	.o_resp_valid(o_resp_valid), .o_resp_data(o_resp_data), .o_err_valid(o_err_valid),
	.o_err_code(o_err_code), .o_trigger(o_trigger), .o_set_free_run(o_set_free_run),
	.o_clear(o_clear), .o_lockout(o_lockout), .o_srq(o_srq), .o_ppoll_dio(o_ppoll_dio),
	.o_spoll_byte(o_spoll_byte));

//--- rtl/gpib_status_poll_trigger_unit.sv
// status byte, service request, trigger, clear, remote/local and poll logic
`timescale 1ns/1ps
module gpib_status_poll_trigger_unit
	import status_poll_pkg::*;
#(
	parameter logic [SELFTEST_W-1:0] SELFTEST_LEN = SELFTEST_W'(SELFTEST_CYCLES)
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// commands from the parser
	input  wire logic        i_cmd_valid,
	input  wire cmd_type     i_cmd,
	input  wire logic [7:0]  i_cmd_data,
	output logic             o_cmd_ready,
	// bus messages from the interface layer
	input  wire logic        i_bus_get,
	input  wire logic        i_bus_dcl,
	input  wire logic        i_bus_sdc,
	input  wire logic        i_bus_gtl,
	input  wire logic        i_bus_llo,
	input  wire logic        i_bus_ren,
	input  wire logic        i_bus_ppc,
	input  wire logic        i_bus_ppu,
	input  wire logic        i_bus_sec_valid,
	input  wire logic [7:0]  i_bus_sec_byte,
	input  wire logic        i_bus_spe,
	input  wire logic        i_bus_spd,
	input  wire logic        i_listen_addr,
	input  wire logic        i_ppoll,
	// status sources
	input  wire logic        i_dev_dep,
	input  wire logic        i_err_queue_nonempty,
	input  wire logic        i_quest_sum,
	input  wire logic        i_out_msg_ready,
	input  wire logic        i_event_sum,
	input  wire logic        i_oper_sum,
	input  wire logic        i_ops_pending,
	input  wire trig_src_type i_trig_src,
	input  wire logic        i_chan_waiting,
	input  wire logic        i_selftest_fail,
	input  wire logic        i_local_key,
	// answers
	output logic             o_resp_valid,
	output logic [7:0]       o_resp_data,
	output logic             o_err_valid,
	output logic [15:0]      o_err_code,
	output logic             o_trigger,
	output logic             o_set_free_run,
	output logic             o_clear,
	output logic             o_remote,
	output logic             o_lockout,
	output logic             o_srq,
	output logic [7:0]       o_ppoll_dio,
	output logic             o_spoll_mode,
	output logic [7:0]       o_spoll_byte
);
	logic [7:0]   service_request_mask_ff;
	logic [7:0]   summary_status_byte;
	logic         master_summary_flag;
	logic         wait_hold_ff;
	logic         ppc_armed_ff;
	logic         pp_enabled_ff;
	logic         pp_sense_ff;
	logic [2:0]   pp_line_ff;
	rl_state_type rl_ff;
	logic         local_key_s;
	logic         dev_clear;
	logic         cmd_take;
	logic         st_busy;
	logic         st_done;
	logic         st_failed;
	logic         st_start;
	logic         trg_any;
	logic         trg_ok;

	// pin input from the front panel passes two flops
	sync2 u_key_sync (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_async   (i_local_key),
		.o_sync    (local_key_s)
	);

	// status byte assembly and summary flag
	always_comb begin
		summary_status_byte              = 8'h00;
		summary_status_byte[DEV_DEP_BIT] = i_dev_dep;
		summary_status_byte[QUEUE_BIT]   = i_err_queue_nonempty;
		summary_status_byte[QUEST_BIT]   = i_quest_sum;
		summary_status_byte[MSG_AVL_BIT] = i_out_msg_ready;
		summary_status_byte[EVENT_BIT]   = i_event_sum;
		summary_status_byte[OPER_BIT]    = i_oper_sum;
		master_summary_flag = |(summary_status_byte & service_request_mask_ff & MASK_KEEP);
		summary_status_byte[SUMMARY_BIT] = master_summary_flag;
	end

	// device clear: universal, or selected only when listening
	assign dev_clear = i_bus_dcl || (i_bus_sdc && i_listen_addr);

	// commands are refused while a wait or a self test holds the parser
	assign o_cmd_ready = !wait_hold_ff && !st_busy && !dev_clear;
	assign cmd_take    = i_cmd_valid && o_cmd_ready;
	assign st_start    = cmd_take && (i_cmd == CMD_TST_QRY);

	// trigger from either command or bus message behaves the same
	assign trg_any = (cmd_take && i_cmd == CMD_TRG) || i_bus_get;
	assign trg_ok  = (i_trig_src == SRC_BUS) && i_chan_waiting;

	// self test timer
	self_test_timer #(
		.CYCLES (SELFTEST_LEN)
	) u_selftest (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_start   (st_start),
		.i_abort   (dev_clear),
		.i_fail    (i_selftest_fail),
		.o_busy    (st_busy),
		.o_done    (st_done),
		.o_failed  (st_failed)
	);

	// service request mask register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn)
			service_request_mask_ff <= MASK_RESET;
		else if (cmd_take && i_cmd == CMD_SRE_SET)
			service_request_mask_ff <= i_cmd_data & MASK_KEEP;
	end

	// wait hold-off: set by wait command, ended by completion or clear
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn)
			wait_hold_ff <= 1'b0;
		else if (dev_clear)
			wait_hold_ff <= 1'b0;
		else if (wait_hold_ff && !i_ops_pending)
			wait_hold_ff <= 1'b0;
		else if (cmd_take && i_cmd == CMD_WAI)
			wait_hold_ff <= i_ops_pending;
	end

	// query answers into the output queue
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_resp_valid <= 1'b0;
			o_resp_data  <= 8'h00;
		end else begin
			o_resp_valid <= 1'b0;
			if (dev_clear) begin
				o_resp_data <= 8'h00;
			end else if (st_done) begin
				o_resp_valid <= 1'b1;
				o_resp_data  <= st_failed ? TST_FAIL_CHAR : TST_PASS_CHAR;
			end else if (cmd_take && i_cmd == CMD_SRE_QRY) begin
				o_resp_valid <= 1'b1;
				o_resp_data  <= service_request_mask_ff & MASK_KEEP;
			end else if (cmd_take && i_cmd == CMD_STB_QRY) begin
				o_resp_valid <= 1'b1;
				o_resp_data  <= summary_status_byte;
			end
		end
	end

	// trigger outcome and error report
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_trigger   <= 1'b0;
			o_err_valid <= 1'b0;
			o_err_code  <= 16'h0000;
		end else begin
			o_trigger   <= trg_any && trg_ok;
			o_err_valid <= trg_any && !trg_ok;
			if (trg_any && !trg_ok)
				o_err_code <= ERR_TRIG_IGNORED;
		end
	end

	// clear pulse towards parser and output buffer
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn)
			o_clear <= 1'b0;
		else
			o_clear <= dev_clear;
	end

	// remote/local with lockout
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			rl_ff          <= LOC_STATE;
			o_set_free_run <= 1'b0;
		end else begin
			o_set_free_run <= 1'b0;
			if (!i_bus_ren) begin
				rl_ff <= LOC_STATE;
			end else if (i_bus_gtl) begin
				o_set_free_run <= 1'b1;
				rl_ff <= (rl_ff == RWLS_STATE || rl_ff == LWLS_STATE) ?
					LWLS_STATE : LOC_STATE;
			end else if (i_bus_llo) begin
				rl_ff <= (rl_ff == REM_STATE || rl_ff == RWLS_STATE) ?
					RWLS_STATE : LWLS_STATE;
			end else begin
				unique case (rl_ff)
					LOC_STATE: begin
						if (i_listen_addr)
							rl_ff <= REM_STATE;
					end
					REM_STATE: begin
						if (local_key_s) begin
							rl_ff          <= LOC_STATE;       // key honoured without lockout
							o_set_free_run <= 1'b1;
						end
					end
					LWLS_STATE: begin
						if (i_listen_addr)
							rl_ff <= RWLS_STATE;
					end
					RWLS_STATE: begin
						rl_ff <= RWLS_STATE;
					end
				endcase
			end
		end
	end

	// remote and lockout outputs from state
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_remote  <= 1'b0;
			o_lockout <= 1'b0;
		end else begin
			o_remote  <= (rl_ff == REM_STATE) || (rl_ff == RWLS_STATE);
			o_lockout <= (rl_ff == LWLS_STATE) || (rl_ff == RWLS_STATE);
		end
	end

	// parallel poll configuration
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			ppc_armed_ff  <= 1'b0;
			pp_enabled_ff <= 1'b0;
			pp_sense_ff   <= 1'b0;
			pp_line_ff    <= 3'h0;
		end else if (i_bus_ppu) begin
			ppc_armed_ff  <= 1'b0;
			pp_enabled_ff <= 1'b0;
		end else if (i_bus_ppc && i_listen_addr) begin
			ppc_armed_ff <= 1'b1;
		end else if (ppc_armed_ff && i_bus_sec_valid) begin
			ppc_armed_ff <= 1'b0;
			if (i_bus_sec_byte[7:4] == PPE_TOP) begin
				pp_enabled_ff <= 1'b1;
				pp_sense_ff   <= i_bus_sec_byte[3];
				pp_line_ff    <= i_bus_sec_byte[2:0];
			end else if (i_bus_sec_byte == PPD_BYTE) begin
				pp_enabled_ff <= 1'b0;
			end
		end
	end

	// parallel poll response: drive the chosen line while the summary flag equals the sense level
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn)
			o_ppoll_dio <= 8'h00;
		else if (i_ppoll && pp_enabled_ff && (master_summary_flag == pp_sense_ff))
			o_ppoll_dio <= 8'h01 << pp_line_ff;
		else
			o_ppoll_dio <= 8'h00;
	end

	// serial poll mode and service request line
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_spoll_mode <= 1'b0;
			o_spoll_byte <= 8'h00;
			o_srq        <= 1'b0;
		end else begin
			if (i_bus_spe)
				o_spoll_mode <= 1'b1;
			else if (i_bus_spd)
				o_spoll_mode <= 1'b0;
			o_spoll_byte <= summary_status_byte;
			o_srq        <= master_summary_flag;
		end
	end
endmodule

//--- rtl/self_test_timer.sv
// self test duration timer with pass/fail result latch
`timescale 1ns/1ps
module self_test_timer
	import status_poll_pkg::*;
#(
	parameter logic [SELFTEST_W-1:0] CYCLES = SELFTEST_W'(SELFTEST_CYCLES)
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	input  wire logic i_start,
	input  wire logic i_abort,
	input  wire logic i_fail,
	output logic      o_busy,
	output logic      o_done,
	output logic      o_failed
);
	logic [SELFTEST_W-1:0] cnt_ff;

	// count down the test time, report once at the end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn || i_abort) begin
			cnt_ff   <= '0;
			o_busy   <= 1'b0;
			o_done   <= 1'b0;
			o_failed <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !o_busy) begin
				cnt_ff   <= CYCLES - SELFTEST_W'(1);
				o_busy   <= 1'b1;
				o_failed <= 1'b0;
			end else if (o_busy) begin
				if (i_fail)
					o_failed <= 1'b1;
				if (cnt_ff == '0) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - SELFTEST_W'(1);
				end
			end
		end
	end
endmodule

//--- rtl/status_poll_pkg.sv
// package of constants and types for the status, poll and trigger unit
package status_poll_pkg;

	// status byte bit positions
	localparam int unsigned DEV_DEP_BIT  = 1;
	localparam int unsigned QUEUE_BIT    = 2;
	localparam int unsigned QUEST_BIT    = 3;
	localparam int unsigned MSG_AVL_BIT  = 4;
	localparam int unsigned EVENT_BIT    = 5;
	localparam int unsigned SUMMARY_BIT  = 6;
	localparam int unsigned OPER_BIT     = 7;

	// mask reset value and kept bits
	localparam logic [7:0] MASK_RESET    = 8'h00;
	localparam logic [7:0] MASK_KEEP     = 8'hbf;

	// parallel poll byte layouts
	localparam logic [3:0] PPE_TOP       = 4'h6;
	localparam logic [7:0] PPD_BYTE      = 8'h70;

	// error code for an ignored trigger
	localparam logic signed [15:0] ERR_TRIG_IGNORED = -16'sd211;

	// self test duration and its cycle count at 100 MHz
	localparam longint unsigned SELFTEST_SEC     = 100;
	localparam longint unsigned CLK_HZ           = 100_000_000;
	localparam longint unsigned SELFTEST_CYCLES  = SELFTEST_SEC * CLK_HZ;
	localparam int unsigned     SELFTEST_W       = 34;

	// self test result characters for the output queue
	localparam logic [7:0] TST_PASS_CHAR = 8'h30;
	localparam logic [7:0] TST_FAIL_CHAR = 8'h31;

	// command codes from the command parser
	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_SRE_SET,
		CMD_SRE_QRY,
		CMD_STB_QRY,
		CMD_TRG,
		CMD_TST_QRY,
		CMD_WAI
	} cmd_type;

	// trigger source settings
	typedef enum logic [1:0] {
		SRC_IMMEDIATE,
		SRC_BUS,
		SRC_EXTERNAL,
		SRC_INTERNAL
	} trig_src_type;

	// local/remote states
	typedef enum logic [1:0] {
		LOC_STATE,
		REM_STATE,
		LWLS_STATE,
		RWLS_STATE
	} rl_state_type;

endpackage

//--- rtl/sync2.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module sync2 (
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_ff;

	// first flop feeds only the second
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			meta_ff <= 1'b0;
			o_sync  <= 1'b0;
		end else begin
			meta_ff <= i_async;
			o_sync  <= meta_ff;
		end
	end
endmodule
